// *** common/crc_monitor_consts.svh ***
`ifndef CRC_MONITOR_CONSTS_SVH
`define CRC_MONITOR_CONSTS_SVH

// Register byte offsets
`define ADDR_CTRL 12'h000
`define ADDR_STATE 12'h004
`define ADDR_IRQ_STATUS 12'h008
`define ADDR_IRQ_MASK 12'h00C
`define ADDR_SIGNATURE 12'h010
`define ADDR_STORED 12'h014
`define ADDR_COMPUTED 12'h018
// Configuration memory window, one word per aligned address
`define CFG_PAGE 4'h1

// Field positions
`define CTRL_EN_BIT 0
`define CTRL_DIV_LSB 8
`define CTRL_DIV_MSB 11
`define STATE_RUN_BIT 0
`define STATE_FLAG_BIT 1
`define STATE_UMODE_BIT 2
`define IRQ_PASS_BIT 0
`define IRQ_ERR_BIT 1

// Reset values
`define CTRL_EN_RESET 1'b0
`define DIV_EXP_RESET 4'h0
`define STORED_RESET 32'h00000000
`define IRQ_RESET 2'h0

// Divider exponent limit and CRC arithmetic
`define DIV_EXP_MAX 4'h8
`define CRC_POLY 32'h04C11DB7
`define CRC_INIT 32'hFFFFFFFF

`endif

// *** common/crc_monitor_pkg.sv ***
`default_nettype none

package crc_monitor_pkg;
	localparam int CFG_AW = 6;
	localparam int CFG_DEPTH = 64;
	localparam logic [5:0] CFG_LAST = 6'h3F;

	typedef enum logic [1:0] {ST_IDLE, ST_PRIME, ST_RUN} scan_state_t;

	typedef struct packed {
		logic enable;
		logic [3:0] div_exp;
	} ctrl_t;

	typedef struct packed {
		logic [31:0] stored;
		logic [31:0] signature;
	} crc_words_t;

	typedef struct packed {
		logic shift;
		logic ldsrc;
	} readout_ctl_t;
endpackage

`default_nettype wire

// *** logic/cfg_memory.sv ***
`default_nettype none

module cfg_memory (
	input wire logic clock_in,
	input wire logic wr_en_in,
	input wire logic [crc_monitor_pkg::CFG_AW-1:0] wr_addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic [crc_monitor_pkg::CFG_AW-1:0] rd_addr_in,
	output logic [31:0] rd_data_out
);
	logic [31:0] mem [0:crc_monitor_pkg::CFG_DEPTH-1];

	// Contents carry no reset: software loads them before user mode
	always_ff @(posedge clock_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	// Registered read port
	always_ff @(posedge clock_in) begin
		rd_data_out <= mem[rd_addr_in];
	end
endmodule

`default_nettype wire

// *** logic/crc_readout.sv ***
`default_nettype none

module crc_readout (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic user_clk_in,
	input wire crc_monitor_pkg::readout_ctl_t ctl_in,
	input wire crc_monitor_pkg::crc_words_t words_in,
	output logic regout_out
);
	logic uclk_q;
	logic low_q;
	logic [31:0] shreg_q;
	logic rise;

	// User clock is sampled as an ordinary synchronous input
	assign rise = user_clk_in & ~uclk_q;

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			uclk_q <= 1'b0;
		end else begin
			uclk_q <= user_clk_in;
		end
	end

	// Remembers whether the previous user edge already saw load mode
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			low_q <= 1'b0;
		end else if (rise) begin
			low_q <= ~ctl_in.shift;
		end
	end

	// Load from the second consecutive low edge on, so a one-edge glitch cannot reload
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			shreg_q <= 32'h00000000;
		end else if (rise) begin
			if (ctl_in.shift) begin
				shreg_q <= {1'b0, shreg_q[31:1]}; // RULE12
			end else if (low_q) begin
				shreg_q <= ctl_in.ldsrc ? words_in.signature : words_in.stored; // RULE13
			end
		end
	end

	assign regout_out = shreg_q[0]; // RULE9

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	chk_shift_step: assert property (rise && ctl_in.shift |=> shreg_q == {1'b0, $past(shreg_q[31:1])}) // RULE12
		else $error("readout shift did not advance one bit");
	chk_short_low: assert property (rise && !ctl_in.shift && !low_q |=> $stable(shreg_q)) // RULE12
		else $error("readout loaded after a single low edge");
	chk_load_source: assert property (rise && !ctl_in.shift && low_q && !ctl_in.ldsrc
		|=> shreg_q == $past(words_in.stored)) // RULE13
		else $error("readout did not load the stored value");
	chk_sig_readout: assert property (rise && !ctl_in.shift && low_q && ctl_in.ldsrc
		|=> shreg_q == $past(words_in.signature)) // RULE9
		else $error("readout did not load the signature");
endmodule

`default_nettype wire

// *** logic/crc_monitor.sv ***
`include "crc_monitor_consts.svh"
`default_nettype none

// Summary of operation
// RULE1: Starts checking alone on user mode entry
// RULE2: Flag low until a pass finds corruption
// RULE3: Raised flag holds through the next pass
// RULE4: Flag shows last pass only, clears when clean
// RULE5: Passes repeat back to back until reset
// RULE6: Checker runs on oscillator, never user clock
// RULE7: Divider is two to power zero..eight
// RULE8: Pass length scales with divider and size
// RULE9: Signature kept in readable 32-bit register
// RULE10: Flag pin driven only when checking enabled
// RULE11: User logic should trust flag, not readout
// RULE12: Shift high shifts, low twice loads
// RULE13: Load select: zero stored, one signature
// RULE14: Flag timed by oscillator, asynchronous to user
// RULE15: Non-zero signature raises the flag
// RULE16: Flag changes only at pass completion; the code also clears it when disabled
module crc_monitor (
	input wire logic clock_in,
	input wire logic reset_n_in,
	input wire logic user_mode_in,
	input wire logic [11:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic user_clk_in,
	input wire logic shift_in,
	input wire logic ldsrc_in,
	output logic regout_out,
	output logic crc_error_out,
	output logic crc_error_oe_out,
	output logic irq_out
);
	crc_monitor_pkg::ctrl_t ctrl_q;
	crc_monitor_pkg::scan_state_t state_q;
	crc_monitor_pkg::scan_state_t state_d;
	crc_monitor_pkg::crc_words_t words;
	crc_monitor_pkg::readout_ctl_t rd_ctl;
	logic [crc_monitor_pkg::CFG_AW-1:0] word_q;
	logic [crc_monitor_pkg::CFG_AW-1:0] word_d;
	logic [31:0] stored_q;
	logic [31:0] signature_q;
	logic [31:0] computed_q;
	logic [31:0] crc_q;
	logic [31:0] crc_next;
	logic [31:0] mem_rdata;
	logic [7:0] div_cnt_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic [1:0] irq_events;
	logic [1:0] irq_clear;
	logic [31:0] rdata_d;
	logic flag_q;
	logic oe_q;
	logic irq_q;
	logic active;
	logic tick;
	logic pass_end;
	logic pass_bad;
	logic cfg_wr;

	// Exponents above the limit fall back to the slowest divider
	function automatic logic [3:0] clamp_exp(input logic [3:0] e);
		clamp_exp = (e > `DIV_EXP_MAX) ? `DIV_EXP_MAX : e;
	endfunction

	// Terminal count of the divider: two to the exponent, minus one
	function automatic logic [7:0] div_mask(input logic [3:0] e);
		logic [8:0] full;
		full = (9'h001 << clamp_exp(e)) - 9'h001;
		div_mask = full[7:0];
	endfunction

	// One configuration word folded into the CRC, most significant bit first
	function automatic logic [31:0] crc_fold(input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			r = (r[31] ^ d[i]) ? ((r << 1) ^ `CRC_POLY) : (r << 1);
		end
		crc_fold = r;
	endfunction

	// Checking needs both the feature enabled and the device in user mode
	assign active = ctrl_q.enable & user_mode_in;
	assign cfg_wr = wr_in && (addr_in[11:8] == `CFG_PAGE);

	// Divided check strobe; clock_in stands for the configuration oscillator
	assign tick = (state_q == crc_monitor_pkg::ST_RUN)
		&& (div_cnt_q == div_mask(ctrl_q.div_exp)); // RULE6 RULE7

	// Read address is the next word so the data is ready with word_q
	cfg_memory u_mem (
		.clock_in(clock_in),
		.wr_en_in(cfg_wr),
		.wr_addr_in(addr_in[7:2]),
		.wr_data_in(wdata_in),
		.rd_addr_in(word_d),
		.rd_data_out(mem_rdata)
	);

	assign crc_next = crc_fold(crc_q, mem_rdata);
	assign pass_bad = (crc_next ^ stored_q) != 32'h00000000; // RULE15

	// Scan sequencing over the whole configuration memory
	always_comb begin
		state_d = state_q;
		word_d = word_q;
		pass_end = 1'b0;
		case (state_q)
			crc_monitor_pkg::ST_IDLE: begin
				word_d = '0;
				if (active) begin
					state_d = crc_monitor_pkg::ST_PRIME; // RULE1
				end
			end
			crc_monitor_pkg::ST_PRIME: begin
				word_d = '0;
				state_d = active ? crc_monitor_pkg::ST_RUN : crc_monitor_pkg::ST_IDLE;
			end
			crc_monitor_pkg::ST_RUN: begin
				if (!active) begin
					state_d = crc_monitor_pkg::ST_IDLE;
					word_d = '0;
				end else if (tick) begin
					if (word_q == crc_monitor_pkg::CFG_LAST) begin
						pass_end = 1'b1; // RULE8
						word_d = '0;
						state_d = crc_monitor_pkg::ST_PRIME; // RULE5
					end else begin
						word_d = word_q + 6'h01;
					end
				end
			end
			default: begin
				state_d = crc_monitor_pkg::ST_IDLE;
				word_d = '0;
			end
		endcase
	end

	// State and word pointer
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= crc_monitor_pkg::ST_IDLE;
			word_q <= '0;
		end else begin
			state_q <= state_d;
			word_q <= word_d;
		end
	end

	// Divider counter restarts on every strobe and outside a scan
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_cnt_q <= 8'h00;
		end else if (state_q != crc_monitor_pkg::ST_RUN || tick) begin
			div_cnt_q <= 8'h00;
		end else begin
			div_cnt_q <= div_cnt_q + 8'h01; // RULE7
		end
	end

	// Running CRC, seeded at the start of every pass
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			crc_q <= `CRC_INIT;
		end else if (state_q == crc_monitor_pkg::ST_PRIME) begin
			crc_q <= `CRC_INIT;
		end else if (tick) begin
			crc_q <= crc_next;
		end
	end

	// Pass results: the signature is the difference from the stored value
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			signature_q <= 32'h00000000;
			computed_q <= 32'h00000000;
		end else if (pass_end) begin
			signature_q <= crc_next ^ stored_q; // RULE9
			computed_q <= crc_next;
		end
	end

	// Flag moves only at a pass boundary or when disabled, so it holds a full pass
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			flag_q <= 1'b0;
		end else if (!ctrl_q.enable) begin
			flag_q <= 1'b0; // RULE10
		end else if (pass_end) begin
			flag_q <= pass_bad; // RULE2 RULE3 RULE4 RULE15 RULE16
		end
	end

	// Pin enable follows the feature switch
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= ctrl_q.enable; // RULE10
		end
	end

	// Pin timed by the checker clock; user logic must resynchronise it
	assign crc_error_out = flag_q; // RULE14
	assign crc_error_oe_out = oe_q;

	// Control register written by software
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_q.enable <= `CTRL_EN_RESET;
			ctrl_q.div_exp <= `DIV_EXP_RESET;
		end else if (wr_in && addr_in == `ADDR_CTRL) begin
			ctrl_q.enable <= wdata_in[`CTRL_EN_BIT];
			ctrl_q.div_exp <= clamp_exp(wdata_in[`CTRL_DIV_MSB:`CTRL_DIV_LSB]); // RULE7
		end
	end

	// Stored reference; rewriting it mid-run injects a mismatch on purpose
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stored_q <= `STORED_RESET;
		end else if (wr_in && addr_in == `ADDR_STORED) begin
			stored_q <= wdata_in;
		end
	end

	// Interrupt events and write-one-to-clear; a new event beats the clear
	assign irq_events = {pass_end & pass_bad, pass_end};
	assign irq_clear = (wr_in && addr_in == `ADDR_IRQ_STATUS)
		? {wdata_in[`IRQ_ERR_BIT], wdata_in[`IRQ_PASS_BIT]} : 2'h0;

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_stat_q <= `IRQ_RESET;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clear) | irq_events;
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_mask_q <= `IRQ_RESET;
		end else if (wr_in && addr_in == `ADDR_IRQ_MASK) begin
			irq_mask_q <= {wdata_in[`IRQ_ERR_BIT], wdata_in[`IRQ_PASS_BIT]};
		end
	end

	// Registered level output, one cycle behind the status bits
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	assign irq_out = irq_q;

	// Read mux; memory window and unmapped addresses read as zero
	always_comb begin
		rdata_d = 32'h00000000;
		case (addr_in)
			`ADDR_CTRL: begin
				rdata_d[`CTRL_EN_BIT] = ctrl_q.enable;
				rdata_d[`CTRL_DIV_MSB:`CTRL_DIV_LSB] = ctrl_q.div_exp;
			end
			`ADDR_STATE: begin
				rdata_d[`STATE_RUN_BIT] = state_q != crc_monitor_pkg::ST_IDLE;
				rdata_d[`STATE_FLAG_BIT] = flag_q;
				rdata_d[`STATE_UMODE_BIT] = user_mode_in;
			end
			`ADDR_IRQ_STATUS: begin
				rdata_d[`IRQ_ERR_BIT] = irq_stat_q[1];
				rdata_d[`IRQ_PASS_BIT] = irq_stat_q[0];
			end
			`ADDR_IRQ_MASK: begin
				rdata_d[`IRQ_ERR_BIT] = irq_mask_q[1];
				rdata_d[`IRQ_PASS_BIT] = irq_mask_q[0];
			end
			`ADDR_SIGNATURE: rdata_d = signature_q;
			`ADDR_STORED: rdata_d = stored_q;
			`ADDR_COMPUTED: rdata_d = computed_q;
			default: rdata_d = 32'h00000000;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_out <= 32'h00000000;
		end else begin
			rdata_out <= rd_in ? rdata_d : 32'h00000000;
		end
	end

	// Serial readout of signature or stored value for user logic
	assign words.stored = stored_q;
	assign words.signature = signature_q;
	assign rd_ctl.shift = shift_in;
	assign rd_ctl.ldsrc = ldsrc_in;

	crc_readout u_readout (
		.clock_in(clock_in),
		.reset_n_in(reset_n_in),
		.user_clk_in(user_clk_in),
		.ctl_in(rd_ctl),
		.words_in(words),
		.regout_out(regout_out)
	);

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_restart;
		state_q == crc_monitor_pkg::ST_PRIME ##1 state_q == crc_monitor_pkg::ST_RUN;
	endsequence

	// A mid-pass strobe followed by four cycles of an unchanged divide-by-four setting
	sequence s_div4_hold;
		tick && !pass_end ##1 (active && ctrl_q.div_exp == 4'h2)[*4];
	endsequence

	chk_auto_start: assert property (state_q == crc_monitor_pkg::ST_IDLE && active
		|=> s_restart) // RULE1
		else $error("scan did not start on user mode entry");
	chk_flag_rise: assert property ($rose(flag_q) |-> $past(pass_end) && $past(pass_bad)) // RULE2
		else $error("flag rose without a bad pass");
	chk_flag_held: assert property (flag_q && !pass_end && ctrl_q.enable |=> flag_q) // RULE3
		else $error("flag dropped in mid pass");
	chk_flag_clears: assert property (pass_end && !pass_bad && ctrl_q.enable |=> !flag_q) // RULE4
		else $error("flag stayed high after a clean pass");
	chk_pass_restart: assert property (pass_end && active |=> s_restart) // RULE5
		else $error("next pass did not follow");
	chk_tick_every: assert property (state_q == crc_monitor_pkg::ST_RUN
		&& ctrl_q.div_exp == 4'h0 |-> tick) // RULE6
		else $error("undivided checker missed a strobe");
	chk_tick_spacing: assert property (s_div4_hold |-> tick && !$past(tick)
		&& !$past(tick, 2) && !$past(tick, 3)) // RULE7
		else $error("divide by four spacing wrong");
	chk_exp_range: assert property (ctrl_q.div_exp <= `DIV_EXP_MAX) // RULE7
		else $error("divider exponent out of range");
	chk_pass_length: assert property (pass_end |-> tick
		&& word_q == crc_monitor_pkg::CFG_LAST) // RULE8
		else $error("pass ended before the last word");
	chk_sig_flag: assert property (pass_end && ctrl_q.enable
		|=> flag_q == (signature_q != 32'h00000000)) // RULE15
		else $error("flag disagrees with signature");
	chk_pin_off: assert property (!ctrl_q.enable |=> !crc_error_oe_out && !crc_error_out) // RULE10
		else $error("flag pin active while disabled");
	chk_flag_once: assert property ($changed(flag_q)
		|-> $past(pass_end) || !$past(ctrl_q.enable)) // RULE16
		else $error("flag changed away from a pass end");
endmodule

`default_nettype wire

// *** dv/user_reader.sv ***
`default_nettype none

// User core side: makes its readout clock only while reading, trusts the flag pin
module user_reader (
	input wire logic clock_in,
	input wire logic regout_in,
	input wire logic crc_error_in,
	output logic user_clk_out,
	output logic shift_out,
	output logic ldsrc_out,
	output logic flag_sync_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic meta_q;

	// Idle: clock parked low, shift high so nothing loads by accident
	initial begin
		user_clk_out = 1'b0;
		shift_out = 1'b1;
		ldsrc_out = 1'b0;
	end

	// Flag comes from another timing domain, so two flops before any use
	always_ff @(posedge clock_in) begin
		meta_q <= crc_error_in;
		flag_sync_out <= meta_q;
	end

	// Half period of two clocks so the sampler sees every level
	task automatic tick(input logic lvl);
		repeat (2) @(posedge clock_in);
		user_clk_out <= lvl;
	endtask

	// Two low rises load, then 31 shift rises, LSB first
	task automatic read_word(input logic src, output logic [31:0] w);
		@(posedge clock_in);
		shift_out <= 1'b0;
		ldsrc_out <= src;
		tick(1'b1);
		tick(1'b0);
		tick(1'b1);
		tick(1'b0);
		w[0] = regout_in;
		shift_out <= 1'b1;
		ldsrc_out <= ~src; // Select must be ignored while shifting
		for (int i = 1; i < 32; i++) begin
			tick(1'b1);
			tick(1'b0);
			w[i] = regout_in;
		end
	endtask
endmodule

`default_nettype wire

// *** dv/test_crc_monitor.sv ***
`include "crc_monitor_consts.svh"
`default_nettype none

module test_crc_monitor;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in, reset_n_in, user_mode_in, wr_in, rd_in;
	logic [11:0] addr_in;
	logic [31:0] wdata_in, rdata_out;
	logic user_clk, shift, ldsrc, regout, crc_error_out, crc_error_oe_out, irq_out, flag_sync;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [31:0] mem [64];
	logic [31:0] good, bad, r;

	crc_monitor dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .user_mode_in(user_mode_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .user_clk_in(user_clk), .shift_in(shift), .ldsrc_in(ldsrc),
		.regout_out(regout), .crc_error_out(crc_error_out),
		.crc_error_oe_out(crc_error_oe_out), .irq_out(irq_out));

	user_reader partner (.clock_in(clock_in), .regout_in(regout), .crc_error_in(crc_error_out),
		.user_clk_out(user_clk), .shift_out(shift), .ldsrc_out(ldsrc),
		.flag_sync_out(flag_sync));

	// 40 MHz clock
	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end

	// Cycle count used to time whole passes
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask

	// Data sampled mid-cycle, in the only cycle it stands
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		@(negedge clock_in);
		d = rdata_out;
	endtask

	// Reference CRC: MSB first, no reflection, no final inversion
	function automatic logic [31:0] crc_of(input logic [31:0] m [64]);
		logic [31:0] c;
		logic fb;
		c = `CRC_INIT;
		for (int i = 0; i < 64; i++) begin
			for (int b = 31; b >= 0; b--) begin
				fb = c[31] ^ m[i][b];
				c = {c[30:0], 1'b0} ^ (fb ? `CRC_POLY : 32'h00000000);
			end
		end
		return c;
	endfunction

	// Clear status, then poll until a pass-done event lands
	task automatic wait_pass;
		int k;
		logic [31:0] s;
		k = 0;
		s = 32'h00000000;
		wr(`ADDR_IRQ_STATUS, 32'h00000003);
		while (s[0] !== 1'b1 && k < 9000) begin
			rd(`ADDR_IRQ_STATUS, s);
			k++;
		end
		if (k >= 9000) n_errors++;
	endtask

	// Waits for the interrupt to drop and rise again
	task automatic wait_irq;
		int k;
		k = 0;
		@(negedge clock_in);
		while (irq_out !== 1'b0 && k < 40000) begin
			@(negedge clock_in);
			k++;
		end
		while (irq_out !== 1'b1 && k < 40000) begin
			@(negedge clock_in);
			k++;
		end
		if (k >= 40000) n_errors++;
	endtask

	// Spacing of back-to-back pass ends for one divider setting
	task automatic pass_len(input logic [3:0] n, input int exp);
		int c1;
		wr(`ADDR_CTRL, {20'h00000, n, 8'h01});
		// Polling copes with a pass end that lands on the clear
		wait_pass;
		wr(`ADDR_IRQ_STATUS, 32'h00000001);
		wait_irq;
		c1 = cyc;
		wr(`ADDR_IRQ_STATUS, 32'h00000001);
		wait_irq;
		chk(32'(cyc - c1), 32'(exp));
	endtask

	// Watchdog sized well above the longest pass measurements
	initial begin
		#(25 * 90000);
		n_errors++;
		test_done;
	end

	initial begin
		reset_n_in = 1'b0;
		user_mode_in = 1'b0;
		addr_in = 12'h000;
		wdata_in = 32'h00000000;
		wr_in = 1'b0;
		rd_in = 1'b0;
		repeat (2) @(posedge clock_in);
		reset_n_in <= 1'b1;
		rd(`ADDR_CTRL, r);
		chk(r, 32'h00000000);
		rd(`ADDR_STORED, r);
		chk(r, 32'h00000000);
		rd(`ADDR_IRQ_MASK, r);
		chk(r, 32'h00000000);
		rd(12'h020, r);
		chk(r, 32'h00000000);
		chk({29'h00000000, crc_error_out, crc_error_oe_out, irq_out}, 32'h00000000);
		$display("test reset values done");

		for (int i = 0; i < 64; i++) begin
			mem[i] = 32'h9E3779B9 * (i + 1);
			wr(12'h100 + 12'(4 * i), mem[i]);
		end
		good = crc_of(mem);
		wr(`ADDR_STORED, good);
		wr(`ADDR_CTRL, 32'h00000001);
		repeat (100) @(posedge clock_in);
		rd(`ADDR_STATE, r);
		chk(r, 32'h00000000);
		@(posedge clock_in);
		user_mode_in <= 1'b1;
		wait_pass;
		wait_pass;
		rd(`ADDR_COMPUTED, r);
		chk(r, good);
		rd(`ADDR_SIGNATURE, r);
		chk(r, 32'h00000000);
		chk({31'h00000000, crc_error_out}, 32'h00000000);
		chk({31'h00000000, crc_error_oe_out}, 32'h00000001);
		chk({31'h00000000, irq_out}, 32'h00000000);
		rd(`ADDR_STATE, r);
		chk(r, 32'h00000005);
		$display("test clean pass done");

		mem[5] = mem[5] ^ 32'h00000100;
		wr(12'h114, mem[5]);
		bad = crc_of(mem);
		wait_pass;
		wait_pass;
		rd(`ADDR_IRQ_STATUS, r);
		chk(r, 32'h00000003);
		rd(`ADDR_SIGNATURE, r);
		chk(r, bad ^ good);
		chk({31'h00000000, crc_error_out}, 32'h00000001);
		rd(`ADDR_STATE, r);
		chk(r, 32'h00000007);
		for (int i = 0; i < 70; i++) begin
			@(negedge clock_in);
			chk({31'h00000000, crc_error_out}, 32'h00000001);
		end
		partner.read_word(1'b1, r);
		chk(r, bad ^ good);
		partner.read_word(1'b0, r);
		chk(r, good);
		chk({31'h00000000, flag_sync}, 32'h00000001);
		$display("test corrupted pass done");

		wr(`ADDR_CTRL, 32'h00000000);
		repeat (2) @(negedge clock_in);
		chk({30'h00000000, crc_error_out, crc_error_oe_out}, 32'h00000000);
		wr(`ADDR_CTRL, 32'h00000001);
		// Still corrupted, so the flag must come back before the repair
		wait_pass;
		chk({31'h00000000, crc_error_out}, 32'h00000001);
		mem[5] = mem[5] ^ 32'h00000100;
		wr(12'h114, mem[5]);
		wait_pass;
		wait_pass;
		chk({31'h00000000, crc_error_out}, 32'h00000000);
		rd(`ADDR_SIGNATURE, r);
		chk(r, 32'h00000000);
		$display("test recovery done");

		wr(`ADDR_IRQ_MASK, 32'h00000001);
		// One priming cycle plus one divided strobe per word
		pass_len(4'h0, 1 + 64);
		pass_len(4'h2, 1 + 64 * 4);
		pass_len(4'h3, 1 + 64 * 8);
		pass_len(4'hF, 1 + 64 * 256);
		rd(`ADDR_CTRL, r);
		chk(r, 32'h00000801);
		$display("test divider done");
		test_done;
	end
endmodule

`default_nettype wire
